// >>> core/float_special_value_logic.v
// Special-value, range and fixed-point datapath for a 60-bit
// one's-complement machine. Assumes the issue logic presents one
// operation per valid cycle and reads results one edge later.
`timescale 1ns/1ps
`include "fsv_defs.vh"
`default_nettype none

// Notes on behaviour
// - Exponent overflow packs zero coefficient, exponent 3777 or 4000 by sign.
// - Infinite operand into float add, multiply or divide raises a selectable exit.
// - Producing infinite or indefinite results never raises an exit alone.
// - Exponent underflow gives all-zero word and no exit.
// - Exponent 0000 with non-zero coefficient stays packed as is.
// - Infinity or zero operands may give indefinite 1777 with zero coefficient.
// - Normalizing indefinite returns it unchanged; shift unit raises no exit.
// - Exit tests happen only in add, multiply, divide on top 12 bits.
// - Only multiply and divide detect plus and minus zero operand forms.
// - Top 3777/4000 mean infinity, 1777/6000 mean indefinite.
// - Generated special results have low 48 bits zero, standard words only.
// - Indefinite and zero results are positive; infinity follows algebraic sign.
// - Float add does no zero detection; odd zero results may emerge.
// - Exponents beyond plus or minus 1777 become infinity or zero.
// - Product and quotient overflow thresholds use offsets 60 and 57.
// - Upper sum overflows only on infinity; 1776 plus carry gives 1777.
// - Normalize underflow zeroes word, keeps shift count; zero gives 60.
// - Pack with fixed zero index inserts bias 2000 without normalizing.
// - Long add does 60-bit one's-complement add and subtract, overflow ignored.
// - Increment does 18-bit one's-complement add and subtract, overflow ignored.
// - Float add accumulates in 97 bits; carry shifts right, bumps exponent.
// - Unrounded multiply gives both product halves; rounded gives upper only.
// - Exits act when sensed; codes combine address, operand, indefinite.
module float_special_value_logic (
  input  wire        clk,                 // 10 MHz clock
  input  wire        rst,                 // Async reset, active high
  input  wire        op_valid,            // Operation issues this cycle
  input  wire [3:0]  op_code,             // Operation select
  input  wire [59:0] op_a,                // First operand word
  input  wire [59:0] op_b,                // Second operand word
  input  wire [17:0] index_val,           // Index register for pack
  input  wire        fixed_zero_index_reg,// Pack uses the zero index
  input  wire [2:0]  exit_select,         // Selected exit conditions
  input  wire        addr_fault,          // Address out of range seen
  output reg  [59:0] result_operand_reg,  // Result word
  output reg  [17:0] shift_count_result,  // Normalize shift count
  output reg         result_valid,        // Result pulse
  output reg         inf_operand_flag,    // Infinite operand used
  output reg         ind_operand_flag,    // Indefinite operand used
  output reg  [2:0]  exit_code,           // All conditions sensed
  output reg         exit_request         // A selected exit fired
);

  // ==========================================================
  // Operand classification
  wire               a_inf, a_ind, a_zero, a_neg;
  wire               b_inf, b_ind, b_zero, b_neg;
  wire signed [13:0] a_exp, b_exp;
  wire [47:0]        a_mag, b_mag;

  operand_classifier u_cls_a (
    .word     (op_a),
    .is_inf   (a_inf),
    .is_ind   (a_ind),
    .is_zero  (a_zero),
    .neg      (a_neg),
    .exp_true (a_exp),
    .mag      (a_mag)
  );

  operand_classifier u_cls_b (
    .word     (op_b),
    .is_inf   (b_inf),
    .is_ind   (b_ind),
    .is_zero  (b_zero),
    .neg      (b_neg),
    .exp_true (b_exp),
    .mag      (b_mag)
  );

  // ==========================================================
  // Fixed-point adders
  wire [59:0] long_sum;
  wire [17:0] inc_sum;

  ones_comp_adder #(.WIDTH(60)) u_long_add (
    .a   (op_a),
    .b   (op_b),
    .sub (op_code == `FSV_OP_LSUB),
    .sum (long_sum)
  );

  ones_comp_adder #(.WIDTH(18)) u_inc_add (
    .a   (op_a[17:0]),
    .b   (op_b[17:0]),
    .sub (op_code == `FSV_OP_ISUB),
    .sum (inc_sum)
  );

  // ==========================================================
  // Helpers
  function [59:0] pack_word;
    input               neg;
    input               ovf;
    input               unf;
    input signed [13:0] e;
    input [47:0]        m;
    reg signed [13:0]   biased;
    reg [59:0]          w;
    begin
      // Negative exponents pack one lower, so minus 1777 lands on 0000.
      biased = e + `FSV_EXP_BIAS - $signed({13'h0000, e[13]});
      w = {1'b0, biased[10:0], m};
      if (ovf || e > `FSV_EXP_MAX) begin
        pack_word = neg ? `FSV_WORD_NINF : `FSV_WORD_PINF;
      end else if (unf || e < -`FSV_EXP_MAX) begin
        pack_word = `FSV_WORD_ZERO;
      end else begin
        pack_word = neg ? ~w : w;
      end
    end
  endfunction

  function [5:0] lead_zeros;
    input [47:0] m;
    integer      k;
    reg          found;
    begin
      lead_zeros = `FSV_ZERO_SHIFT;
      found = 1'b0;
      for (k = 47; k >= 0; k = k - 1) begin
        if (!found && m[k]) begin
          lead_zeros = 6'd47 - k[5:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  function [59:0] inf_word;
    input neg;
    begin
      inf_word = neg ? `FSV_WORD_NINF : `FSV_WORD_PINF;
    end
  endfunction

  // ==========================================================
  // Floating add: magnitudes aligned in a 97-bit magnitude sum
  reg               b_eff_neg, big_neg, sml_neg, sum_neg;
  reg signed [13:0] big_exp, add_exp;
  reg [13:0]        exp_diff;
  reg [95:0]        big_acc, sml_acc;
  reg [96:0]        acc;
  reg [47:0]        add_mag;
  reg [59:0]        add_word;

  always @* begin
    b_eff_neg = b_neg ^ (op_code == `FSV_OP_FSUB);
    if (a_exp >= b_exp) begin
      big_exp  = a_exp;
      exp_diff = a_exp - b_exp;
      big_acc  = {a_mag, 48'h0000_0000_0000};
      sml_acc  = {b_mag, 48'h0000_0000_0000};
      big_neg  = a_neg;
      sml_neg  = b_eff_neg;
    end else begin
      big_exp  = b_exp;
      exp_diff = b_exp - a_exp;
      big_acc  = {b_mag, 48'h0000_0000_0000};
      sml_acc  = {a_mag, 48'h0000_0000_0000};
      big_neg  = b_eff_neg;
      sml_neg  = a_neg;
    end
    sml_acc = (exp_diff >= `FSV_ACC_SPAN) ? 96'h0 : sml_acc >> exp_diff;
    if (big_neg == sml_neg) begin
      acc     = {1'b0, big_acc} + {1'b0, sml_acc};
      sum_neg = big_neg;
    end else if (big_acc >= sml_acc) begin
      acc     = {1'b0, big_acc - sml_acc};
      sum_neg = big_neg;
    end else begin
      acc     = {1'b0, sml_acc - big_acc};
      sum_neg = sml_neg;
    end
    // A carry out of the upper half shifts right once.
    if (acc[96]) begin
      add_mag = acc[96:49];
      add_exp = big_exp + 14'sh0001;
    end else begin
      add_mag = acc[95:48];
      add_exp = big_exp;
    end
    // Zero forms pass straight through the sum.
    add_word = pack_word(sum_neg, 1'b0, 1'b0, add_exp, add_mag);
    if (a_ind || b_ind) begin
      add_word = `FSV_WORD_IND;
    end else if (a_inf && b_inf) begin
      add_word = (a_neg == b_eff_neg) ? inf_word(a_neg)
                                       : `FSV_WORD_IND;
    end else if (a_inf) begin
      add_word = inf_word(a_neg);
    end else if (b_inf) begin
      add_word = inf_word(b_eff_neg);
    end
  end

  // ==========================================================
  // Floating multiply: full 96-bit product
  reg               prod_neg;
  reg signed [13:0] exp_sum, mul_exp;
  reg [95:0]        product;
  reg [47:0]        mul_mag;
  reg               mul_ovf, mul_unf;
  reg [59:0]        mul_word;

  always @* begin
    prod_neg = a_neg ^ b_neg;
    exp_sum  = a_exp + b_exp;
    product  = a_mag * b_mag;
    if (op_code == `FSV_OP_FMUL_RND) begin
      product = product + {48'h0000_0000_0000, 1'b1, 47'h0};
    end
    if (op_code == `FSV_OP_FMUL_LO) begin
      mul_mag = product[47:0];
      mul_exp = exp_sum;
      mul_ovf = exp_sum > `FSV_EXP_MAX;
      mul_unf = exp_sum - 14'sh0001 < -`FSV_EXP_MAX;
    end else begin
      mul_ovf = exp_sum + `FSV_UP_OFS > `FSV_EXP_MAX;
      mul_unf = exp_sum + `FSV_DIV_OFS < -`FSV_EXP_MAX;
      if (product[95]) begin
        mul_mag = product[95:48];
        mul_exp = exp_sum + `FSV_UP_OFS;
      end else begin
        mul_mag = product[94:47];
        mul_exp = exp_sum + `FSV_DIV_OFS;
      end
    end
    mul_word = pack_word(prod_neg, mul_ovf, mul_unf, mul_exp, mul_mag);
    if (a_ind || b_ind) begin
      mul_word = `FSV_WORD_IND;
    end else if ((a_inf && b_zero) || (a_zero && b_inf)) begin
      mul_word = `FSV_WORD_IND;
    end else if (a_inf || b_inf) begin
      mul_word = inf_word(prod_neg);
    end else if (a_zero || b_zero) begin
      mul_word = `FSV_WORD_ZERO;
    end
  end

  // ==========================================================
  // Floating divide
  reg signed [13:0] exp_dif, div_exp;
  reg [95:0]        quot;
  reg [47:0]        div_mag;
  reg               div_ovf, div_unf;
  reg [59:0]        div_word;

  always @* begin
    exp_dif = a_exp - b_exp;
    quot    = (b_mag == 48'h0000_0000_0000) ? 96'h0
              : {a_mag, 48'h0000_0000_0000} / {48'h0000_0000_0000, b_mag};
    div_ovf = exp_dif - `FSV_DIV_OFS > `FSV_EXP_MAX;
    div_unf = exp_dif - `FSV_UP_OFS < -`FSV_EXP_MAX;
    if (quot[48]) begin
      div_mag = quot[48:1];
      div_exp = exp_dif - `FSV_DIV_OFS;
    end else begin
      div_mag = quot[47:0];
      div_exp = exp_dif - `FSV_UP_OFS;
    end
    div_word = pack_word(prod_neg, div_ovf, div_unf, div_exp, div_mag);
    if (a_ind || b_ind) begin
      div_word = `FSV_WORD_IND;
    end else if ((a_inf && b_inf) || (a_zero && b_zero)) begin
      div_word = `FSV_WORD_IND;
    end else if (a_inf || b_zero || b_mag == 48'h0000_0000_0000) begin
      div_word = inf_word(prod_neg);
    end else if (a_zero || b_inf) begin
      div_word = `FSV_WORD_ZERO;
    end
  end

  // ==========================================================
  // Normalize and pack, both in the shift unit
  reg [5:0]         lz;
  reg signed [13:0] norm_exp, pack_exp;
  reg [59:0]        norm_word, pack_word_v;
  reg [17:0]        idx;

  always @* begin
    lz       = lead_zeros(a_mag);
    norm_exp = a_exp - $signed({8'h00, lz});
    if (a_ind) begin
      norm_word = op_a;
    end else if (a_mag == 48'h0000_0000_0000) begin
      norm_word = `FSV_WORD_ZERO;
    end else begin
      norm_word = pack_word(a_neg, 1'b0, 1'b0, norm_exp,
                            a_mag << lz);
    end
    idx = fixed_zero_index_reg ? 18'h0_0000 : index_val;
    if (idx[`FSV_IDX_SIGN]) begin
      pack_exp = -$signed({1'b0, ~idx[12:0]});
    end else begin
      pack_exp = $signed({1'b0, idx[12:0]});
    end
    // Coefficient goes in as given; no normalizing on pack.
    pack_word_v = pack_word(op_a[`FSV_SIGN_BIT], 1'b0, 1'b0, pack_exp,
                            op_a[`FSV_SIGN_BIT] ? ~op_a[47:0]
                                                : op_a[47:0]);
  end

  // ==========================================================
  // Result select and exit sensing
  reg        is_float;
  reg        next_inf, next_ind;
  reg [2:0]  next_code;
  reg [59:0] next_result;
  reg [17:0] next_shift;

  always @* begin
    is_float = op_code <= `FSV_OP_FDIV;
    next_inf = op_valid && is_float && (a_inf || b_inf);
    next_ind = op_valid && is_float && (a_ind || b_ind);
    next_shift = shift_count_result;
    case (op_code)
      `FSV_OP_FADD, `FSV_OP_FSUB: begin
        next_result = add_word;
      end
      `FSV_OP_FMUL_UP, `FSV_OP_FMUL_RND, `FSV_OP_FMUL_LO: begin
        next_result = mul_word;
      end
      `FSV_OP_FDIV: begin
        next_result = div_word;
      end
      `FSV_OP_NORM: begin
        next_result = norm_word;
        next_shift  = a_ind ? 18'h0_0000 : {12'h000, lz};
      end
      `FSV_OP_PACK: begin
        next_result = pack_word_v;
      end
      `FSV_OP_LADD, `FSV_OP_LSUB: begin
        next_result = long_sum;
      end
      `FSV_OP_IADD, `FSV_OP_ISUB: begin
        next_result = {{42{inc_sum[`FSV_IDX_SIGN]}}, inc_sum};
      end
      default: begin
        next_result = result_operand_reg;
      end
    endcase
    // Generated specials feed no exit bit; only operands and addr_fault do.
    next_code = 3'h0;
    next_code[`FSV_EXIT_ADDR] = addr_fault;
    next_code[`FSV_EXIT_OPER] = next_inf;
    next_code[`FSV_EXIT_IND]  = next_ind;
  end

  // ==========================================================
  // Output registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result_operand_reg <= `FSV_RST_WORD;
      shift_count_result <= 18'h0_0000;
      result_valid       <= 1'b0;
      inf_operand_flag   <= 1'b0;
      ind_operand_flag   <= 1'b0;
      exit_code          <= 3'h0;
      exit_request       <= 1'b0;
    end else begin
      result_valid     <= op_valid;
      inf_operand_flag <= next_inf;
      ind_operand_flag <= next_ind;
      exit_code        <= next_code;
      exit_request     <= |(next_code & exit_select);
      if (op_valid) begin
        result_operand_reg <= next_result;
        shift_count_result <= next_shift;
      end
    end
  end

endmodule // float_special_value_logic

`default_nettype wire

// >>> core/fsv_defs.vh
// Constants shared by the special-value datapath, its operand classifier, the checker and the bench.
// Assumes a 60-bit one's-complement word with an 11-bit biased exponent.
`ifndef FSV_DEFS_VH
`define FSV_DEFS_VH

// ==========================================================
// Operation codes
`define FSV_OP_FADD     4'h0
`define FSV_OP_FSUB     4'h1
`define FSV_OP_FMUL_UP  4'h2
`define FSV_OP_FMUL_RND 4'h3
`define FSV_OP_FMUL_LO  4'h4
`define FSV_OP_FDIV     4'h5
`define FSV_OP_NORM     4'h6
`define FSV_OP_PACK     4'h7
`define FSV_OP_LADD     4'h8
`define FSV_OP_LSUB     4'h9
`define FSV_OP_IADD     4'hA
`define FSV_OP_ISUB     4'hB

// ==========================================================
// Word layout
`define FSV_SIGN_BIT    59
`define FSV_EXP_HI      58
`define FSV_EXP_LO      48
`define FSV_COEF_HI     47
`define FSV_IDX_SIGN    17

// ==========================================================
// Exponent arithmetic, signed 14-bit true exponents
`define FSV_EXP_BIAS    14'sh0400
`define FSV_EXP_MAX     14'sh03FF
`define FSV_UP_OFS      14'sh0030
`define FSV_DIV_OFS     14'sh002F
`define FSV_ZERO_SHIFT  6'h30
`define FSV_ACC_SPAN    14'h0060

// ==========================================================
// Top-twelve-bit operand classes
`define FSV_TOP_PINF    12'h07FF
`define FSV_TOP_NINF    12'h0800
`define FSV_TOP_PIND    12'h03FF
`define FSV_TOP_NIND    12'h0C00
`define FSV_TOP_PZERO   12'h0000
`define FSV_TOP_NZERO   12'h0FFF

// ==========================================================
// Standard generated words and reset values
`define FSV_WORD_PINF   60'h7FF_0000_0000_0000
`define FSV_WORD_NINF   60'h800_0000_0000_0000
`define FSV_WORD_IND    60'h3FF_0000_0000_0000
`define FSV_WORD_ZERO   60'h000_0000_0000_0000
`define FSV_RST_WORD    60'h000_0000_0000_0000

// ==========================================================
// Exit code bit positions
`define FSV_EXIT_ADDR   0
`define FSV_EXIT_OPER   1
`define FSV_EXIT_IND    2

`endif

// >>> core/ones_comp_adder.v
// One's-complement adder with end-around carry, add or subtract.
// Purely combinational; overflow is dropped by the caller's width.
`timescale 1ns/1ps
`default_nettype none

module ones_comp_adder #(
  parameter WIDTH = 60
) (
  input  wire [WIDTH-1:0] a,    // First operand
  input  wire [WIDTH-1:0] b,    // Second operand
  input  wire             sub,  // High to subtract b
  output wire [WIDTH-1:0] sum   // One's-complement result
);

  wire [WIDTH-1:0] b_eff;
  wire [WIDTH:0]   raw;

  assign b_eff = sub ? ~b : b;
  assign raw   = {1'b0, a} + {1'b0, b_eff};
  // The carry out folds back in; a second carry cannot arise.
  assign sum   = raw[WIDTH-1:0] + {{(WIDTH-1){1'b0}}, raw[WIDTH]};

endmodule // ones_comp_adder

`default_nettype wire

// >>> core/operand_classifier.v
// Classifies one packed floating operand and unpacks it.
// Assumes a 60-bit one's-complement word; purely combinational.
`timescale 1ns/1ps
`include "fsv_defs.vh"
`default_nettype none

module operand_classifier (
  input  wire [59:0]        word,     // Packed operand
  output wire               is_inf,   // Plus or minus infinity
  output wire               is_ind,   // Plus or minus indefinite
  output wire               is_zero,  // Plus or minus zero form
  output wire               neg,      // Sign bit
  output wire signed [13:0] exp_true, // Unbiased exponent
  output wire [47:0]        mag       // Coefficient magnitude
);

  wire [11:0] top;
  wire [59:0] absw;

  assign top  = word[59:48];
  assign neg  = word[`FSV_SIGN_BIT];
  assign absw = neg ? ~word : word;

  assign is_inf  = (top == `FSV_TOP_PINF)  | (top == `FSV_TOP_NINF);
  assign is_ind  = (top == `FSV_TOP_PIND)  | (top == `FSV_TOP_NIND);
  assign is_zero = (top == `FSV_TOP_PZERO) | (top == `FSV_TOP_NZERO);

  // Exponents are one's complement: below the bias, packed 1777 is minus
  // zero and packed 0000 is minus 1777, so that side sits one higher.
  assign exp_true = $signed({3'b000, absw[`FSV_EXP_HI:`FSV_EXP_LO]})
                    - `FSV_EXP_BIAS
                    + $signed({13'h0000, ~absw[`FSV_EXP_HI]});
  assign mag      = absw[`FSV_COEF_HI:0];

endmodule // operand_classifier

`default_nettype wire

// >>> dv/fsv_checker.sv
// Port checker for the special-value datapath.
// Bound to the datapath's top module; one clock, async reset.
`timescale 1ns/1ps
`include "fsv_defs.vh"
`default_nettype none
// ==========================================================
// Checker
module fsv_checker (
  input wire logic        clk,                  // Clock
  input wire logic        rst,                  // Reset
  input wire logic        op_valid,             // Issue
  input wire logic [3:0]  op_code,              // Operation
  input wire logic [59:0] op_a,                 // Operand a
  input wire logic [59:0] op_b,                 // Operand b
  input wire logic        fixed_zero_index_reg, // Zero index
  input wire logic [2:0]  exit_select,          // Selected exits
  input wire logic        addr_fault,           // Address fault
  input wire logic [59:0] result_operand_reg,   // Result
  input wire logic        result_valid,         // Result pulse
  input wire logic        inf_operand_flag,     // Infinite seen
  input wire logic        ind_operand_flag,     // Indefinite seen
  input wire logic [2:0]  exit_code,            // Sensed exits
  input wire logic        exit_request          // Exit fired
);
  wire [11:0] top_a = op_a[59:48];
  wire [11:0] top_b = op_b[59:48];
  wire [47:0] coef_a = op_a[47:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  answer_next_a:
    assert property (1'b1 |=> result_valid == $past(op_valid))
    else $error("result pulse misplaced");
  inf_product_a:
    assert property (op_valid && op_code == `FSV_OP_FMUL_UP &&
      top_a == `FSV_TOP_PINF && top_b == 12'h400
      |=> result_operand_reg == `FSV_WORD_PINF)
    else $error("infinite product wrong");
  inf_flag_a:
    assert property (op_valid && op_code <= `FSV_OP_FDIV &&
      (top_a == `FSV_TOP_PINF || top_a == `FSV_TOP_NINF)
      |=> inf_operand_flag && exit_code[1])
    else $error("infinite operand not flagged");
  float_only_a:
    assert property (op_valid && op_code > `FSV_OP_FDIV
      |=> !inf_operand_flag && !ind_operand_flag)
    else $error("operand flag outside float units");
  norm_ind_a:
    assert property (op_valid && op_code == `FSV_OP_NORM &&
      top_a == `FSV_TOP_PIND
      |=> result_operand_reg == $past(op_a) && !exit_code[2])
    else $error("indefinite normalize changed");
  pack_bias_a:
    assert property (op_valid && op_code == `FSV_OP_PACK &&
      fixed_zero_index_reg && op_a[59:47] == 13'h0000
      |=> result_operand_reg == {12'h400, $past(coef_a)})
    else $error("pack bias wrong");
  exit_req_a:
    assert property (exit_request == |(exit_code & $past(exit_select)))
    else $error("exit request mismatch");
  addr_code_a:
    assert property (addr_fault |=> exit_code[0])
    else $error("address fault not sensed");
  cover property (op_valid && op_code == `FSV_OP_NORM);
  cover property (exit_request);
  cover property (op_valid ##1 op_valid);
endmodule // fsv_checker
bind float_special_value_logic fsv_checker u_fsv_checker (
  .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
  .op_a(op_a), .op_b(op_b),
  .fixed_zero_index_reg(fixed_zero_index_reg),
  .exit_select(exit_select), .addr_fault(addr_fault),
  .result_operand_reg(result_operand_reg),
  .result_valid(result_valid), .inf_operand_flag(inf_operand_flag),
  .ind_operand_flag(ind_operand_flag), .exit_code(exit_code),
  .exit_request(exit_request));
`default_nettype wire

// >>> dv/issue_model.sv
// Issue-side model: presents one operation per call.
// Assumes callers start 1 ns after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Issue model
module issue_model (
  input  wire logic        clk,      // Clock
  output var  logic        op_valid, // Issue strobe
  output var  logic [3:0]  op_code,  // Operation
  output var  logic [59:0] op_a,     // Operand a
  output var  logic [59:0] op_b      // Operand b
);
  initial begin
    op_valid = 1'b0;
    op_code = 4'h0;
    op_a = 60'h0;
    op_b = 60'h0;
  end
  // A strobe dropped in this step must not rise in the same step, so an
  // idle edge passes first; keep holds it up for back-to-back issue.
  task issue(input [3:0] op, input [59:0] a, input [59:0] b,
             input keep);
    begin
      if (!op_valid) begin
        @(posedge clk);
        #1;
        op_valid = 1'b1;
      end
      op_code = op;
      op_a = a;
      op_b = b;
      @(posedge clk);
      #1;
      if (!keep)
        op_valid = 1'b0;
    end
  endtask
endmodule // issue_model
`default_nettype wire

// >>> dv/test_float_special_value_logic.sv
// Self-checking bench for the special-value datapath.
// Assumes the issue model and the bound port checker.
`timescale 1ns/1ps
`include "fsv_defs.vh"
`default_nettype none
// ==========================================================
// Bench top
module test_float_special_value_logic;
  localparam [59:0] pinf = `FSV_WORD_PINF;
  localparam [59:0] ninf = `FSV_WORD_NINF;
  localparam [59:0] one_w = 60'h400_8000_0000_0000;
  localparam [59:0] nzero = 60'hFFF_FFFF_FFFF_FFFF;
  localparam [59:0] big_w = 60'h600_8000_0000_0000;
  localparam [59:0] ind_w = 60'h3FF_1234_5678_9ABC;
  logic        clk;
  logic        rst;
  logic [17:0] index_val;
  logic        fixed_zero_index_reg;
  logic [2:0]  exit_select;
  logic        addr_fault;
  logic [63:0] r;
  logic [59:0] a;
  logic [3:0]  op;
  wire         op_valid;
  wire [3:0]   op_code;
  wire [59:0]  op_a;
  wire [59:0]  op_b;
  wire [59:0]  result;
  wire [17:0]  shift_count;
  wire         rvalid;
  wire         inf_flag;
  wire         ind_flag;
  wire [2:0]   exit_code;
  wire         exit_req;
  wire [6:0]   flags = {rvalid, exit_req, exit_code, ind_flag, inf_flag};
  integer      failures;
  integer      n_tests;
  integer      seed;
  integer      i;
  issue_model im (.clk(clk), .op_valid(op_valid), .op_code(op_code),
    .op_a(op_a), .op_b(op_b));
  float_special_value_logic DUT (.clk(clk), .rst(rst),
    .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
    .index_val(index_val), .fixed_zero_index_reg(fixed_zero_index_reg),
    .exit_select(exit_select), .addr_fault(addr_fault),
    .result_operand_reg(result), .shift_count_result(shift_count),
    .result_valid(rvalid), .inf_operand_flag(inf_flag),
    .ind_operand_flag(ind_flag), .exit_code(exit_code),
    .exit_request(exit_req));
  // Fixed-point sums with end-around carry, built apart from the design.
  function [59:0] fx(input [3:0] o, input [59:0] x, input [59:0] y);
    reg [60:0] t;
    reg [18:0] u;
    reg [59:0] n;
    begin
      n = o[0] ? ~y : y;
      t = {1'b0, x} + {1'b0, n};
      u = {1'b0, x[17:0]} + {1'b0, n[17:0]};
      t[59:0] = t[59:0] + {59'h0, t[60]};
      u[17:0] = u[17:0] + {17'h0, u[18]};
      fx = o[1] ? {{42{u[17]}}, u[17:0]} : t[59:0];
    end
  endfunction
  task chk(input string name, input [59:0] e, input [59:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("ERROR %s expected %h seen %h", name, e, g);
      end
    end
  endtask
  task run(input [3:0] o, input [59:0] x, input [59:0] y, input keep,
           input ck, input [59:0] er, input [6:0] ef);
    begin
      im.issue(o, x, y, keep);
      if (ck)
        chk("result", er, result);
      chk("flags", {53'h0, ef}, {53'h0, flags});
    end
  endtask
  task test_done;
    begin
      $display("Checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1_000_000;
    failures = failures + 1;
    test_done;
  end
  initial begin
    failures = 0;
    n_tests = 0;
    seed = 4;
    rst = 1'b1;
    index_val = 18'h0_0000;
    fixed_zero_index_reg = 1'b0;
    exit_select = 3'h2;
    addr_fault = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("reset", 60'h0, {35'h0, shift_count, flags} | result);
    run(`FSV_OP_FMUL_UP, pinf, one_w, 0, 1, pinf, 7'h69);
    run(`FSV_OP_FMUL_UP, pinf, ~one_w, 0, 1, ninf, 7'h69);
    run(`FSV_OP_FMUL_UP, one_w, nzero, 0, 1, 60'h0, 7'h40);
    run(`FSV_OP_FDIV, 60'h0, nzero, 0, 1, `FSV_WORD_IND, 7'h40);
    run(`FSV_OP_FDIV, pinf, nzero, 0, 1, ninf, 7'h69);
    a = 60'h040_8000_0000_0000;
    run(`FSV_OP_FMUL_LO, a, a, 0, 1, 60'h0, 7'h40);
    run(`FSV_OP_FMUL_LO, big_w, big_w, 0, 1, pinf, 7'h40);
    run(`FSV_OP_FMUL_LO, big_w, ~big_w, 0, 1, ninf, 7'h40);
    a = 60'h7E8_8000_0000_0000;
    r = 64'h03B8_8000_0000_0000;
    run(`FSV_OP_FDIV, a, r[59:0], 0, 1, pinf, 7'h40);
    run(`FSV_OP_NORM, 60'h400_0000_0000_0000, 0, 0, 1, 0, 7'h40);
    chk("shift count", 60'h30, {42'h0, shift_count});
    run(`FSV_OP_NORM, ind_w, 0, 0, 1, ind_w, 7'h40);
    fixed_zero_index_reg = 1'b1;
    a = 60'h000_0000_0001_2345;
    r = 64'h0400_0000_0001_2345;
    run(`FSV_OP_PACK, a, 0, 0, 1, r[59:0], 7'h40);
    fixed_zero_index_reg = 1'b0;
    index_val = 18'h3_FC00;
    run(`FSV_OP_PACK, 60'h1234, 0, 0, 1, 60'h1234, 7'h40);
    exit_select = 3'h0;
    run(`FSV_OP_FADD, pinf, pinf, 0, 1, pinf, 7'h49);
    exit_select = 3'h4;
    run(`FSV_OP_FMUL_UP, ind_w, one_w, 0, 0, 0, 7'h72);
    run(`FSV_OP_LADD, pinf, 60'h1, 0, 1, fx(4'h8, pinf, 1), 7'h40);
    exit_select = 3'h1;
    addr_fault = 1'b1;
    @(posedge clk);
    #1;
    addr_fault = 1'b0;
    chk("address exit", 60'h24, {53'h0, flags});
    // Back-to-back fixed-point traffic keeps the strobe up throughout.
    for (i = 0; i < 24; i = i + 1) begin
      r = {$random(seed), $random(seed)};
      a = r[59:0];
      r = {$random(seed), $random(seed)};
      op = 4'h8 + {2'h0, r[63:62]};
      index_val = r[17:0];
      run(op, a, r[59:0], i != 23, 1, fx(op, a, r[59:0]), 7'h40);
    end
    test_done;
  end
endmodule // test_float_special_value_logic
`default_nettype wire
